/* File: logic/dpl_pkg.sv */
/*
 * Shared constants, types and the CRC-32 routine of the downstream link framer.
 * Assumes one clock domain and a 32-bit APB register bus.
 */
package dpl_pkg;

  localparam int CW_BITS = 384;
  localparam int NIBBLES = 96;
  localparam int SUBCARRIERS = 8;
  localparam int SYMS_PER_CW = 12;
  localparam logic [6:0] PRE_LAST_SYM = 7'h07;
  localparam logic [6:0] FRAME_LAST_SYM = 7'h7F;
  localparam logic [3:0] CW_LAST_T = 4'hB;

  // block type codes
  localparam logic [3:0] TYPE_HDR = 4'h9;
  localparam logic [3:0] TYPE_PROBE = 4'hA;
  localparam logic [3:0] TYPE_MGMT = 4'hB;
  localparam logic [3:0] TYPE_PARITY = 4'hC;

  // profile select codes
  localparam logic [1:0] SEL_A = 2'h0;
  localparam logic [1:0] SEL_B = 2'h3;

  // preamble: mask of subcarriers carrying pattern A, patterns msb = first symbol
  localparam logic [7:0] PRE_MASK_A = 8'hE9;
  localparam logic [7:0] PRE_PAT_A = 8'hA3;
  localparam logic [7:0] PRE_PAT_B = 8'h09;

  localparam logic [14:0] BCAST_LO = 15'h7F00;
  localparam logic [14:0] BCAST_HI = 15'h7FF0;

  // header data word layout (64 bits, then 32-bit crc)
  localparam int HDR_TYPE_LSB = 60;
  localparam int HDR_DS_LSB = 58;
  localparam int HDR_US_LSB = 56;
  localparam int HDR_RF_LSB = 48;
  localparam int HDR_DA_LSB = 33;
  localparam int HDR_TS_LSB = 1;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LINK = 8'h04;
  localparam logic [7:0] REG_HDR = 8'h08;
  localparam logic [7:0] REG_ADDR = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_TIME = 8'h14;
  localparam logic [7:0] REG_ERR = 8'h18;

  localparam int CTRL_TX_EN = 0;
  localparam int CTRL_PERMIT = 1;
  localparam int CTRL_DS_SW = 2;
  localparam int CTRL_US_SW = 3;

  localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;

  typedef enum logic [1:0] {RX_HDR, RX_PROBE, RX_MGMT, RX_PAD} dpl_rx_state_t;

  // msb-first crc-32 over one 64-bit data word, result complemented
  function automatic logic [31:0] dpl_crc32(input logic [63:0] data);
    logic [31:0] c;
    c = CRC_INIT;
    for (int i = 63; i >= 0; i--) begin
      c = (c[31] ^ data[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return ~c;
  endfunction : dpl_crc32

endpackage : dpl_pkg

/* File: logic/dpl_cw_if.sv */
/*
 * Carrier between the framer and its nibble interleaver.
 * Assumes both ends run on the framer clock.
 */
`timescale 1ns/1ns
interface dpl_cw_if;
  logic load;
  logic [383:0] cw;
  logic [3:0] t;
  logic [31:0] v;

  modport framer (output load, output cw, output t, input v);
  modport ilv (input load, input cw, input t, output v);
endinterface : dpl_cw_if

/* File: logic/dpl_interleaver.sv */
/*
 * Holds one codeword as 96 nibbles and presents the eight nibbles of symbol t.
 * Assumes the framer loads a codeword before its first symbol is read.
 */
`timescale 1ns/1ns
module dpl_interleaver
  import dpl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  dpl_cw_if.ilv port
);

  logic [3:0] mem [NIBBLES];

  genvar i;
  generate
    for (i = 0; i < NIBBLES; i++) begin : g_store
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mem[i] <= 4'h0;
        end else if (port.load) begin
          mem[i] <= port.cw[4*i +: 4];
        end
      end
    end
  endgenerate

  genvar f;
  generate
    for (f = 0; f < SUBCARRIERS; f++) begin : g_read
      assign port.v[4*f +: 4] = mem[7'(port.t) + 7'(SYMS_PER_CW * f)];
    end
  endgenerate

endmodule : dpl_interleaver

/* File: logic/dpl_framer.sv */
/*
 * Downstream link framer: frame build, codeword interleaving, switchover, receive parser.
 * Assumes sym_tick pulses once per OFDM symbol; FEC and scrambler lie outside.
 */
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ns
module dpl_framer
  import dpl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sym_tick,
  input wire logic [383:0] cw_data,
  output logic cw_take,
  output logic tx_sym_valid,
  output logic [6:0] tx_sym_index,
  output logic tx_preamble,
  output logic [31:0] tx_nibbles,
  output logic [7:0] tx_bpsk_neg,
  output logic [95:0] tx_hdr_block,
  output logic tx_hdr_valid,
  output logic tx_ds_profile_b,
  output logic [11:0] tx_link_start,
  input wire logic rx_frame_start,
  input wire logic rx_probe_start,
  input wire logic rx_blk_valid,
  input wire logic [63:0] rx_blk_data,
  input wire logic [31:0] rx_blk_crc,
  output logic rx_probe_valid,
  output logic rx_mgmt_valid,
  output logic [63:0] rx_blk_out,
  output logic rx_ds_profile_b,
  output logic rx_us_profile_b,
  output logic [31:0] local_time
);

  ////////////////////////////////////////////////////////////////////////////
  // register bus

  logic tx_en;
  logic permit;
  logic [14:0] tx_dest;
  logic [7:0] tx_rf_index;
  logic [14:0] own_addr;
  logic [15:0] crc_err_cnt;
  logic [15:0] order_err_cnt;
  logic [1:0] sel [2];
  logic [1:0] busy;
  logic [1:0] sw_req;
  logic bus_wr;
  logic ctrl_wr;
  logic addr_ok;

  assign bus_wr = psel && penable && pready && pwrite;
  assign ctrl_wr = bus_wr && (paddr == REG_CTRL);
  assign addr_ok = (paddr == REG_CTRL) || (paddr == REG_LINK) || (paddr == REG_HDR) ||
                   (paddr == REG_ADDR) || (paddr == REG_STATUS) ||
                   (paddr == REG_TIME) || (paddr == REG_ERR);

  // answer in the first access cycle, wait-state free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          REG_CTRL: prdata <= {28'h0, sw_req, permit, tx_en};
          REG_LINK: prdata <= {20'h0, tx_link_start};
          REG_HDR: prdata <= {9'h0, tx_rf_index, tx_dest};
          REG_ADDR: prdata <= {17'h0, own_addr};
          REG_STATUS: prdata <= {23'h0, rx_us_profile_b, rx_ds_profile_b,
                                 tx_ds_profile_b, busy, sel[1], sel[0]};
          REG_TIME: prdata <= local_time;
          REG_ERR: prdata <= {order_err_cnt, crc_err_cnt};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_en <= 1'b0;
      permit <= 1'b0;
      tx_link_start <= 12'h000;
      tx_dest <= 15'h0000;
      tx_rf_index <= 8'h00;
      own_addr <= 15'h0000;
    end else if (bus_wr) begin
      case (paddr)
        REG_CTRL: begin
          tx_en <= pwdata[CTRL_TX_EN];
          permit <= pwdata[CTRL_PERMIT];
        end
        REG_LINK: tx_link_start <= pwdata[11:0];
        REG_HDR: begin
          tx_dest <= pwdata[14:0];
          tx_rf_index <= pwdata[22:15];
        end
        REG_ADDR: own_addr <= pwdata[14:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit symbol sequencing

  dpl_cw_if cwi ();

  dpl_interleaver u_ilv (
    .pclk(pclk),
    .presetn(presetn),
    .port(cwi.ilv)
  );

  logic [6:0] sym_cnt;
  logic [3:0] t_cnt;
  logic step;
  logic frame_tick;
  logic in_pre;
  logic [7:0] pre_col;
  logic [31:0] pre_nib;
  logic [2:0] pre_pos;

  assign step = sym_tick && tx_en;
  assign frame_tick = step && (sym_cnt == 7'h00);
  assign in_pre = (sym_cnt <= PRE_LAST_SYM);
  assign pre_pos = 3'(PRE_LAST_SYM - sym_cnt);

  // preamble column for this symbol, subcarrier 0 in bit 0
  assign pre_col = (PRE_MASK_A & {8{PRE_PAT_A[pre_pos]}}) |
                   (~PRE_MASK_A & {8{PRE_PAT_B[pre_pos]}});

  genvar f;
  generate
    for (f = 0; f < SUBCARRIERS; f++) begin : g_pre
      assign pre_nib[4*f +: 4] = {3'b000, pre_col[f]};
    end
  endgenerate

  // load a codeword one symbol early so the interleaver is ready for its first symbol
  assign cwi.load = step && ((sym_cnt == PRE_LAST_SYM) ||
                    (!in_pre && t_cnt == CW_LAST_T && sym_cnt != FRAME_LAST_SYM));
  assign cwi.cw = cw_data;
  assign cwi.t = t_cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sym_cnt <= 7'h00;
      t_cnt <= 4'h0;
    end else if (!tx_en) begin
      sym_cnt <= 7'h00;
      t_cnt <= 4'h0;
    end else if (sym_tick) begin
      sym_cnt <= sym_cnt + 7'h01;
      if (!in_pre) begin
        t_cnt <= (t_cnt == CW_LAST_T) ? 4'h0 : t_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_sym_valid <= 1'b0;
      tx_sym_index <= 7'h00;
      tx_preamble <= 1'b0;
      tx_nibbles <= 32'h0;
      tx_bpsk_neg <= 8'h00;
      cw_take <= 1'b0;
    end else begin
      tx_sym_valid <= step;
      cw_take <= cwi.load;
      if (step) begin
        tx_sym_index <= sym_cnt;
        tx_preamble <= in_pre;
        if (in_pre) begin
          tx_nibbles <= pre_nib;
          tx_bpsk_neg <= pre_col;
        end else begin
          tx_nibbles <= cwi.v;
          tx_bpsk_neg <= 8'h00;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // profile switchover, index 0 downstream, 1 upstream

  logic [1:0] next_sel [2];

  genvar d;
  generate
    for (d = 0; d < 2; d++) begin : g_prof
      logic up;
      logic steady;
      logic up_n;

      assign steady = (sel[d] == SEL_A) || (sel[d] == SEL_B);
      assign up_n = busy[d] ? up : (sel[d] == SEL_A);

      always_comb begin
        next_sel[d] = sel[d];
        if (busy[d] || (sw_req[d] && steady)) begin
          next_sel[d] = up_n ? sel[d] + 2'h1 : sel[d] - 2'h1;
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sel[d] <= SEL_A;
          busy[d] <= 1'b0;
          up <= 1'b0;
          sw_req[d] <= 1'b0;
        end else begin
          // software request only after it has refreshed the spare copy
          if (ctrl_wr && pwdata[CTRL_DS_SW + d]) begin
            sw_req[d] <= 1'b1;
          end else if (frame_tick && !busy[d]) begin
            sw_req[d] <= 1'b0;
          end
          if (frame_tick) begin
            sel[d] <= next_sel[d];
            up <= up_n;
            busy[d] <= (next_sel[d] != SEL_A) && (next_sel[d] != SEL_B);
          end
        end
      end
    end
  endgenerate

  // active from the frame after the final value is announced
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ds_profile_b <= 1'b0;
    end else if (frame_tick) begin
      if (sel[0] == SEL_B) begin
        tx_ds_profile_b <= 1'b1;
      end else if (sel[0] == SEL_A) begin
        tx_ds_profile_b <= 1'b0;
      end
    end
  end

  // header data word; the parity, probe and message blocks come from outside
  logic [63:0] hdr_data;
  assign hdr_data = {TYPE_HDR, next_sel[0], next_sel[1], tx_rf_index, tx_dest,
                     local_time, 1'b0};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_hdr_block <= 96'h0;
      tx_hdr_valid <= 1'b0;
    end else begin
      tx_hdr_valid <= frame_tick;
      if (frame_tick) begin
        tx_hdr_block <= {hdr_data, dpl_crc32(hdr_data)};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive block parser

  dpl_rx_state_t rx_state;
  logic [3:0] rx_type;
  logic [14:0] rx_da;
  logic crc_ok;
  logic da_match;
  logic frame_addr_ok;
  logic [1:0] rx_us_sel;
  logic [1:0] rx_ds_sel;
  logic [7:0] rx_frame_idx;
  logic [7:0] pend_rf;
  logic pend_us;
  logic pend_val;
  logic armed;
  logic load_time;

  assign rx_type = rx_blk_data[HDR_TYPE_LSB +: 4];
  assign rx_da = rx_blk_data[HDR_DA_LSB +: 15];
  assign crc_ok = (dpl_crc32(rx_blk_data) == rx_blk_crc);
  assign da_match = (rx_da == own_addr) ||
                    ((rx_da >= BCAST_LO) && (rx_da <= BCAST_HI));
  assign load_time = rx_blk_valid && crc_ok && rx_state == RX_HDR &&
                     rx_type == TYPE_HDR && da_match && !permit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      local_time <= 32'h0;
    end else if (load_time) begin
      local_time <= rx_blk_data[HDR_TS_LSB +: 32];
    end else begin
      local_time <= local_time + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state <= RX_HDR;
      frame_addr_ok <= 1'b0;
      rx_probe_valid <= 1'b0;
      rx_mgmt_valid <= 1'b0;
      rx_blk_out <= 64'h0;
      crc_err_cnt <= 16'h0;
      order_err_cnt <= 16'h0;
    end else begin
      rx_probe_valid <= 1'b0;
      rx_mgmt_valid <= 1'b0;
      if (rx_frame_start) begin
        rx_state <= RX_HDR;
        frame_addr_ok <= 1'b0;
      end else if (rx_blk_valid && !crc_ok) begin
        crc_err_cnt <= crc_err_cnt + 16'h1;
      end else if (rx_blk_valid) begin
        rx_blk_out <= rx_blk_data;
        case (rx_state)
          RX_HDR: begin
            if (rx_type == TYPE_HDR) begin
              frame_addr_ok <= da_match;
              rx_state <= RX_PROBE;
            end else begin
              order_err_cnt <= order_err_cnt + 16'h1;
            end
          end
          RX_PROBE: begin
            if (rx_type == TYPE_PROBE) begin
              rx_probe_valid <= 1'b1;
              rx_state <= RX_MGMT;
            end else begin
              order_err_cnt <= order_err_cnt + 16'h1;
            end
          end
          RX_MGMT: begin
            // any number until the parity block
            if (rx_type == TYPE_MGMT) begin
              rx_mgmt_valid <= frame_addr_ok;
            end else if (rx_type == TYPE_PARITY) begin
              rx_state <= RX_PAD;
            end else begin
              order_err_cnt <= order_err_cnt + 16'h1;
            end
          end
          RX_PAD: ;
          default: rx_state <= RX_HDR;
        endcase
      end
    end
  end

  // unit side profile copies
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_ds_sel <= SEL_A;
      rx_us_sel <= SEL_A;
      rx_ds_profile_b <= 1'b0;
      rx_us_profile_b <= 1'b0;
      rx_frame_idx <= 8'h00;
      pend_rf <= 8'h00;
      pend_us <= 1'b0;
      pend_val <= 1'b0;
      armed <= 1'b0;
    end else begin
      if (rx_blk_valid && crc_ok && rx_state == RX_HDR && rx_type == TYPE_HDR) begin
        rx_ds_sel <= rx_blk_data[HDR_DS_LSB +: 2];
        rx_us_sel <= rx_blk_data[HDR_US_LSB +: 2];
        if ((rx_blk_data[HDR_US_LSB +: 2] == SEL_B) != rx_us_profile_b &&
            (rx_blk_data[HDR_US_LSB +: 2] == SEL_A ||
             rx_blk_data[HDR_US_LSB +: 2] == SEL_B)) begin
          pend_us <= 1'b1;
          pend_val <= (rx_blk_data[HDR_US_LSB +: 2] == SEL_B);
          pend_rf <= rx_blk_data[HDR_RF_LSB +: 8];
          armed <= 1'b0;
        end
      end
      if (rx_frame_start) begin
        rx_frame_idx <= rx_frame_idx + 8'h1;
        if (pend_us && rx_frame_idx == pend_rf) begin
          armed <= 1'b1;
        end
        if (rx_ds_sel == SEL_B) begin
          rx_ds_profile_b <= 1'b1;
        end else if (rx_ds_sel == SEL_A) begin
          rx_ds_profile_b <= 1'b0;
        end
      end
      if (rx_probe_start && armed) begin
        rx_us_profile_b <= pend_val;
        pend_us <= 1'b0;
        armed <= 1'b0;
      end
    end
  end

endmodule : dpl_framer

/* File: verification/dpl_framer_monitor.sv */
/* Checker on the framer ports: symbols, preamble, codeword loads, receive pulses.
   Assumes a bind into dpl_framer and one clock. */
`timescale 1ns/1ns
module dpl_framer_monitor
  import dpl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sym_tick,
  input wire logic cw_take,
  input wire logic tx_sym_valid,
  input wire logic [6:0] tx_sym_index,
  input wire logic tx_preamble,
  input wire logic [31:0] tx_nibbles,
  input wire logic [7:0] tx_bpsk_neg,
  input wire logic [95:0] tx_hdr_block,
  input wire logic tx_hdr_valid,
  input wire logic tx_ds_profile_b,
  input wire logic rx_probe_start,
  input wire logic rx_blk_valid,
  input wire logic [63:0] rx_blk_data,
  input wire logic rx_mgmt_valid,
  input wire logic [63:0] rx_blk_out,
  input wire logic rx_us_profile_b
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [6:0] last_idx;
  logic [2:0] col;
  logic [7:0] pre_row;
  logic [31:0] pre_nib;
  assign col = 3'h7 - tx_sym_index[2:0];
  always_comb begin
    for (int f = 0; f < 8; f++) begin
      pre_row[f] = PRE_MASK_A[f] ? PRE_PAT_A[col] : PRE_PAT_B[col];
      pre_nib[4*f +: 4] = {3'h0, tx_bpsk_neg[f]};
    end
  end
  // first symbol after reset expects 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_idx <= 7'h7F;
    end else if (tx_sym_valid) begin
      last_idx <= tx_sym_index;
    end
  end
  sequence took(logic [3:0] code);
    rx_blk_valid && rx_blk_data[63:60] == code;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  sym_answer_a: assert property (tx_sym_valid |-> $past(sym_tick))
    else $error("symbol output without a tick");
  index_step_a: assert property (tx_sym_valid |-> tx_sym_index == 7'h00 ||
    tx_sym_index == last_idx + 7'h01) else $error("symbol index skipped");
  pre_flag_a: assert property (tx_sym_valid |-> tx_preamble == (tx_sym_index < 7'h08))
    else $error("preamble flag wrong");
  pre_pattern_a: assert property (tx_sym_valid && tx_preamble |-> tx_bpsk_neg == pre_row)
    else $error("preamble pattern wrong");
  pre_bpsk_a: assert property (tx_sym_valid && tx_preamble |-> tx_nibbles == pre_nib)
    else $error("preamble point wrong");
  data_bpsk_a: assert property (tx_sym_valid && !tx_preamble |-> tx_bpsk_neg == 8'h00)
    else $error("data symbol marked bpsk");
  cw_load_a: assert property (cw_take |-> tx_sym_valid && tx_sym_index inside
    {7'h07, 7'h13, 7'h1F, 7'h2B, 7'h37, 7'h43, 7'h4F, 7'h5B, 7'h67, 7'h73})
    else $error("codeword taken off boundary");
  hdr_mark_a: assert property (tx_hdr_valid |-> tx_sym_valid &&
    tx_sym_index == 7'h00 && tx_hdr_block[95:92] == TYPE_HDR) else $error("header misplaced");
  ds_switch_a: assert property ($changed(tx_ds_profile_b) |-> tx_sym_valid &&
    tx_sym_index == 7'h00) else $error("profile changed mid frame");
  us_switch_a: assert property ($changed(rx_us_profile_b) |-> $past(rx_probe_start))
    else $error("upstream profile changed off probe start");
  mgmt_source_a: assert property (rx_mgmt_valid |->
    $past(rx_blk_valid && rx_blk_data[63:60] == TYPE_MGMT)) else $error("spurious message");
  blk_copy_a: assert property (took(TYPE_MGMT) ##1 rx_mgmt_valid |->
    rx_blk_out == $past(rx_blk_data)) else $error("accepted block altered");
endmodule : dpl_framer_monitor
bind dpl_framer dpl_framer_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .sym_tick(sym_tick), .cw_take(cw_take),
  .tx_sym_valid(tx_sym_valid), .tx_sym_index(tx_sym_index), .tx_preamble(tx_preamble),
  .tx_nibbles(tx_nibbles), .tx_bpsk_neg(tx_bpsk_neg), .tx_hdr_block(tx_hdr_block),
  .tx_hdr_valid(tx_hdr_valid), .tx_ds_profile_b(tx_ds_profile_b),
  .rx_probe_start(rx_probe_start), .rx_blk_valid(rx_blk_valid), .rx_blk_data(rx_blk_data),
  .rx_mgmt_valid(rx_mgmt_valid), .rx_blk_out(rx_blk_out), .rx_us_profile_b(rx_us_profile_b)
);

/* File: verification/dpl_peer.sv */
/* Far-side model: symbol clock, codeword source and head-end block sender.
   Assumes one bench process calls send_blk and mark. */
`timescale 1ns/1ns
module dpl_peer
(
  input wire logic pclk,
  input wire logic presetn,
  output logic sym_tick,
  output logic [383:0] cw_data,
  output logic rx_frame_start,
  output logic rx_probe_start,
  output logic rx_blk_valid,
  output logic [63:0] rx_blk_data,
  output logic [31:0] rx_blk_crc
);
  logic [1:0] tick_div;
  function automatic logic [31:0] crc32(input logic [63:0] d);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    for (int i = 63; i >= 0; i--) begin
      c = (c[31] ^ d[i]) ? ((c << 1) ^ 32'h04C11DB7) : (c << 1);
    end
    return ~c;
  endfunction : crc32
  initial begin
    for (int i = 0; i < 96; i++) begin
      cw_data[4*i +: 4] = 4'(i * 7);
    end
    {rx_frame_start, rx_probe_start, rx_blk_valid, rx_blk_data, rx_blk_crc} = 99'h0;
  end
  // free-running tick, one in four cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_div <= 2'h0;
      sym_tick <= 1'h0;
    end else begin
      tick_div <= tick_div + 2'h1;
      sym_tick <= tick_div == 2'h3;
    end
  end
  task automatic send_blk(input logic [63:0] d, input logic bad);
    @(posedge pclk);
    rx_blk_valid <= 1'h1;
    rx_blk_data <= d;
    rx_blk_crc <= crc32(d) ^ {31'h0, bad};
    @(posedge pclk);
    rx_blk_valid <= 1'h0;
    // no stale block once released
    rx_blk_data <= ~d;
    rx_blk_crc <= ~crc32(d);
  endtask : send_blk
  task automatic mark(input logic probe);
    @(posedge pclk);
    rx_frame_start <= !probe;
    rx_probe_start <= probe;
    @(posedge pclk);
    rx_frame_start <= 1'h0;
    rx_probe_start <= 1'h0;
  endtask : mark
endmodule : dpl_peer

/* File: verification/downstream_phy_link_framer_bench.sv */
/* Self-checking bench: registers, transmit frames, switchover, receive parser.
   Assumes dpl_peer on the far side and the monitor bound in. */
`timescale 1ns/1ns
module downstream_phy_link_framer_bench
  import dpl_pkg::*;
;
  localparam logic [31:0] HDR_W = 32'h0001_0123;
  localparam logic [63:0] PROBE = {4'hA, 60'h0};
  localparam logic [63:0] MGMT = {4'hB, 60'h123456789ABCDEF};
  localparam logic [63:0] PARITY = {4'hC, 60'h0};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hung;
  logic [7:0] paddr, tx_bpsk_neg;
  logic [31:0] pwdata, prdata, tx_nibbles, local_time, rx_blk_crc, ts;
  logic sym_tick, cw_take, tx_sym_valid, tx_preamble, tx_hdr_valid, tx_ds_profile_b;
  logic [383:0] cw_data;
  logic [6:0] tx_sym_index;
  logic [95:0] tx_hdr_block;
  logic [11:0] tx_link_start;
  logic rx_frame_start, rx_probe_start, rx_blk_valid, rx_probe_valid, rx_mgmt_valid;
  logic rx_ds_profile_b, rx_us_profile_b;
  logic [63:0] rx_blk_data, rx_blk_out;
  logic [14:0] da_tab [5] = '{15'h0123, 15'h7F00, 15'h7FF0, 15'h7FF1, 15'h0124};
  int bad_count, total_checks;
  dpl_framer dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sym_tick(sym_tick), .cw_data(cw_data), .cw_take(cw_take), .tx_sym_valid(tx_sym_valid),
    .tx_sym_index(tx_sym_index), .tx_preamble(tx_preamble), .tx_nibbles(tx_nibbles),
    .tx_bpsk_neg(tx_bpsk_neg), .tx_hdr_block(tx_hdr_block), .tx_hdr_valid(tx_hdr_valid),
    .tx_ds_profile_b(tx_ds_profile_b), .tx_link_start(tx_link_start),
    .rx_frame_start(rx_frame_start), .rx_probe_start(rx_probe_start),
    .rx_blk_valid(rx_blk_valid), .rx_blk_data(rx_blk_data), .rx_blk_crc(rx_blk_crc),
    .rx_probe_valid(rx_probe_valid), .rx_mgmt_valid(rx_mgmt_valid), .rx_blk_out(rx_blk_out),
    .rx_ds_profile_b(rx_ds_profile_b), .rx_us_profile_b(rx_us_profile_b),
    .local_time(local_time)
  );
  dpl_peer u_peer (
    .pclk(pclk), .presetn(presetn), .sym_tick(sym_tick), .cw_data(cw_data),
    .rx_frame_start(rx_frame_start), .rx_probe_start(rx_probe_start),
    .rx_blk_valid(rx_blk_valid), .rx_blk_data(rx_blk_data), .rx_blk_crc(rx_blk_crc)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'h1;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (n >= 16) hung = 1'h1;
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(a, 1'h1, d, q, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic e;
    apb(a, 1'h0, 32'h0, q, e);
    chk(q, x);
    chk(e, xe);
  endtask : rd
  function automatic logic [63:0] hdr(input logic [1:0] us, input logic [7:0] rf,
                                      input logic [14:0] da, input logic [31:0] t);
    return {4'h9, us, us, rf, da, t, 1'h0};
  endfunction : hdr
  // one whole frame from the next symbol 0
  task automatic watch(output logic [1:0] ds);
    int n;
    logic [31:0] x;
    logic [7:0] r;
    for (int s = 0; s < 128; s++) begin
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (!(tx_sym_valid === 1'h1 && (s > 0 || tx_sym_index === 7'h00)) && n < 1000);
      if (n >= 1000) hung = 1'h1;
      for (int f = 0; f < 8; f++) begin
        r[f] = s < 8 && (PRE_MASK_A[f] ? PRE_PAT_A[3'(7 - s)] : PRE_PAT_B[3'(7 - s)]);
        x[4*f +: 4] = s < 8 ? {3'h0, r[f]} : 4'(7 * ((s - 8) % 12 + 12 * f));
      end
      chk(tx_sym_index, s);
      chk(tx_preamble, s < 8);
      chk(tx_nibbles, x);
      chk(tx_bpsk_neg, r);
      if (s == 0) begin
        chk(tx_hdr_valid, 1'h1);
        chk(tx_hdr_block[95:92], 4'h9);
        chk(tx_hdr_block[87:65], HDR_W[22:0]);
        chk(tx_hdr_block[31:0], u_peer.crc32(tx_hdr_block[95:32]));
        ds = tx_hdr_block[91:90];
      end
    end
  endtask : watch
  task automatic blk(input logic [63:0] d, input logic bad, input logic ep, input logic em);
    u_peer.send_blk(d, bad);
    #1;
    chk(rx_probe_valid, ep);
    chk(rx_mgmt_valid, em);
    if (ep | em) chk(rx_blk_out, d);
  endtask : blk
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'h0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    int c;
    c = 0;
    while (c < 60000 && hung !== 1'h1) begin
      @(posedge pclk);
      c++;
    end
    bad_count++;
    final_report;
  end
  initial begin
    logic [1:0] ds, prev;
    int steps;
    {presetn, psel, penable, pwrite, hung} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    rd(REG_STATUS, 32'h0, 1'h0);
    wr(REG_ADDR, 32'h0123);
    wr(REG_HDR, HDR_W);
    wr(REG_LINK, 32'h2A5);
    wr(8'h1C, 32'hFFF);
    rd(8'h1C, 32'h0, 1'h1);
    rd(REG_LINK, 32'h2A5, 1'h0);
    chk(tx_link_start, 12'h2A5);
    wr(REG_CTRL, 32'h1);
    watch(prev);
    chk(prev, 2'h0);
    wr(REG_CTRL, 32'h5);
    steps = 0;
    repeat (5) begin
      watch(ds);
      chk(ds === prev || ds === prev + 2'h1, 1'h1);
      steps += ds !== prev;
      prev = ds;
    end
    chk(ds, 2'h3);
    chk(steps, 3);
    chk(tx_ds_profile_b, 1'h1);
    for (int k = 0; k < 5; k++) begin
      ts = {4'(k), 28'h0};
      u_peer.mark(1'h0);
      blk(hdr(2'h0, 8'h00, da_tab[k], ts), 1'h0, 1'h0, 1'h0);
      chk(local_time - ts < 32'h4, k < 3);
      blk(PROBE, 1'h0, 1'h1, 1'h0);
      blk(MGMT, 1'h1, 1'h0, 1'h0);
      repeat (3) blk(MGMT, 1'h0, 1'h0, k < 3);
      blk(PARITY, 1'h0, 1'h0, 1'h0);
      blk(MGMT, 1'h0, 1'h0, 1'h0);
    end
    rd(REG_ERR, 32'h5, 1'h0);
    u_peer.mark(1'h0);
    blk(PROBE, 1'h0, 1'h0, 1'h0);
    rd(REG_ERR, 32'h0001_0005, 1'h0);
    wr(REG_CTRL, 32'h3);
    u_peer.mark(1'h0);
    blk(hdr(2'h3, 8'h0A, 15'h0123, 32'h0), 1'h0, 1'h0, 1'h0);
    chk(rx_us_profile_b, 1'h0);
    chk(local_time[31:28], 4'h2);
    repeat (5) begin
      u_peer.mark(1'h0);
      u_peer.mark(1'h1);
    end
    #1;
    chk(rx_us_profile_b, 1'h1);
    chk(rx_ds_profile_b, 1'h1);
    final_report;
  end
endmodule : downstream_phy_link_framer_bench
